// >>> hdl/rgi_map.vh
// Purpose: Register offsets, defaults and timing counts for the regulator I2C target
// Assumes: 50 MHz system clock
// Notes: Definitions only
`ifndef RGI_MAP_VH
`define RGI_MAP_VH
`define RGI_REG_SET_LOW 3'h1
`define RGI_REG_SET_HIGH 3'h2
`define RGI_REG_CONFIG 3'h3
`define RGI_REG_FLAGS 3'h5
`define RGI_SET_DEFAULT 8'h64
`define RGI_CONFIG_DEFAULT 8'h6F
`define RGI_FLAGS_DEFAULT 8'h00
`define RGI_CONFIG_RESET_BIT 7
`define RGI_ADDR_MSB_VALUE 1'b1
`define RGI_MASTER_CODE_TOP 5'h01
`define RGI_CLK_PERIOD_NS 20
`define RGI_STARTUP_WAIT_US 1000
`define RGI_STARTUP_WAIT_CYCLES ((`RGI_STARTUP_WAIT_US * 1000) / `RGI_CLK_PERIOD_NS)
`endif

// >>> hdl/rgi_sync.v
// Purpose: Two flip-flop synchroniser for a group of asynchronous levels
// Assumes: Inputs come from outside the i_clk domain
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module rgi_sync #(
    parameter WIDTH = 2,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
    // Clocking
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    // Data
    input wire [WIDTH-1:0] i_async,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] meta;

    // Plain double register; reset to the idle bus level
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta <= INIT;
            o_sync <= INIT;
        end else if (i_ce) begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/rgi_startup_timer.v
// Purpose: Start-up wait timer that blocks register writes after a soft reset
// Assumes: One-cycle launch pulse from the register bank
// Notes: Count is a parameter so simulation can shorten it
`timescale 1ns/10ps
`default_nettype none
module rgi_startup_timer #(
    parameter WAIT_CYCLES = 50000
) (
    // Clocking
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    // Control
    input wire i_launch,
    output wire o_busy
);
    reg [31:0] count;

    // Reload on launch, count down to zero
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            count <= 32'h00000000;
        end else if (i_ce) begin
            if (i_launch) begin
                count <= WAIT_CYCLES;
            end else if (count != 32'h00000000) begin
                count <= count - 32'h00000001;
            end
        end
    end

    assign o_busy = (count != 32'h00000000);
endmodule
`default_nettype wire

// >>> hdl/rgi_target.v
// Purpose: I2C target with four-register bank for a step-down regulator
// Assumes: SCL and SDA sampled by i_clk (50 MHz); 3.4 Mbps clock high is
//          about 7 cycles, enough for two-flop sync plus edge detection
// Notes: SDA output enable is active low (low = pulling the line low)
// How it works
// - Start is SDA falling while SCL high, seen in any state.
// - SDA sampled on SCL rise, changed only after SCL falls.
// - Acknowledge address only on match, holding SDA low in ninth clock.
// - Direction 0 writes to device, 1 reads; receiver acknowledges bytes.
// - Units of eight data bits plus acknowledge repeat until stop.
// - Stop is SDA rising while SCL high; release bus, await start.
// - Reads of unimplemented register addresses return 0x00.
// - Master code 00001XXX is not acknowledged but enters high speed.
// - After master code a repeated start; same framing at higher rate.
// - A stop leaves high speed operation.
// - Write is address, register address byte, data byte, each acknowledged.
// - Data byte commits on falling edge of its acknowledge clock.
// - Enable falling edge or supply loss restores all register defaults.
// - Writing reset bit restores defaults and launches a new start-up.
// - Registers are not writable until the start-up wait elapses.
// - Setpoint registers at 0x01 and 0x02 default to 0x64.
// - Configuration at 0x03 defaults 0x6F; flags register at 0x05.
// - Address MSB is one, six bits from strap, LSB is direction.
// - Register address byte uses its low three bits as the index.
// - Flags latch until reset or read; read returns then clears them.
// - Configuration bit 7 is the software reset bit.
`timescale 1ns/10ps
`default_nettype none
`include "rgi_map.vh"
module rgi_target #(
    parameter STARTUP_WAIT_CYCLES = `RGI_STARTUP_WAIT_CYCLES
) (
    // Clocking
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_ce,
    // I2C pins (SCL input only, SDA open drain)
    input wire i_scl,
    input wire i_sda,
    output wire o_sda,
    output wire o_sda_oe_n,
    // Strap and power
    input wire [5:0] i_addr_strap,
    input wire i_enable,
    input wire i_supply_lost,
    // Flag events from the converter
    input wire i_evt_thermal_warn,
    input wire i_evt_hiccup,
    input wire i_evt_uvlo,
    // Register contents to the converter
    output reg [7:0] o_output_voltage_setpoint_low,
    output reg [7:0] o_output_voltage_setpoint_high,
    output reg [7:0] o_converter_configuration,
    output reg [7:0] o_latched_flag_report,
    output reg o_startup_launch,
    output wire o_startup_busy,
    output reg o_high_speed_operation
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_PTR = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;
    localparam ST_IGNORE = 3'h5;

    wire [3:0] sync_out;
    wire scl_s;
    wire sda_s;
    wire en_s;
    wire vin_lost_s;
    reg scl_d;
    reg sda_d;
    reg en_d;
    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [2:0] ptr;
    reg ack_drive;
    reg tx_drive;
    reg [7:0] tx_byte;
    reg ack_phase;
    reg ack_valid;
    reg read_nack;

    // Pins and power inputs pass two flops before use
    rgi_sync #(.WIDTH(4), .INIT(4'h7)) u_sync (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_async({i_supply_lost, i_enable, i_sda, i_scl}),
        .o_sync(sync_out)
    );
    assign scl_s = sync_out[0];
    assign sda_s = sync_out[1];
    assign en_s = sync_out[2];
    assign vin_lost_s = sync_out[3];

    rgi_startup_timer #(.WAIT_CYCLES(STARTUP_WAIT_CYCLES)) u_timer (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ce(i_ce),
        .i_launch(o_startup_launch),
        .o_busy(o_startup_busy)
    );

    // Read mux; unmapped indices give zero
    function [7:0] rgi_read_mux;
        input [2:0] idx;
        input [7:0] lo, hi, cfg, flg;
        begin
            case (idx)
                `RGI_REG_SET_LOW: rgi_read_mux = lo;
                `RGI_REG_SET_HIGH: rgi_read_mux = hi;
                `RGI_REG_CONFIG: rgi_read_mux = cfg;
                `RGI_REG_FLAGS: rgi_read_mux = flg;
                default: rgi_read_mux = 8'h00;
            endcase
        end
    endfunction

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;
    wire en_fall = en_d & ~en_s;
    wire hw_reset = en_fall | vin_lost_s;
    wire [7:0] shreg_next = {shreg[6:0], sda_s};
    wire [6:0] own_addr = {`RGI_ADDR_MSB_VALUE, i_addr_strap};
    // Commit point: SCL falling at the end of a data byte's acknowledge
    wire commit = scl_fall & ack_phase & ack_valid & (state == ST_WDATA);
    wire soft_reset = commit & (ptr == `RGI_REG_CONFIG) & shreg[`RGI_CONFIG_RESET_BIT];
    wire write_ok = commit & ~o_startup_busy;
    // Read of flags is taken when the byte is loaded for transmission
    reg load_read;

    // Only drives low: open drain, oe_n low while pulling
    assign o_sda = 1'b0;
    assign o_sda_oe_n = ~(ack_drive | (tx_drive & ~tx_byte[7]));

    // Edge history of synchronised levels
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            en_d <= 1'b1;
        end else if (i_ce) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            en_d <= en_s;
        end
    end

    // Bus protocol engine
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            ptr <= 3'h0;
            ack_drive <= 1'b0;
            tx_drive <= 1'b0;
            tx_byte <= 8'h00;
            ack_phase <= 1'b0;
            ack_valid <= 1'b0;
            read_nack <= 1'b0;
            load_read <= 1'b0;
            o_high_speed_operation <= 1'b0;
        end else if (i_ce) begin
            load_read <= 1'b0;
            if (stop_cond) begin
                // Release everything, drop back to slower settings
                state <= ST_IDLE;
                ack_drive <= 1'b0;
                tx_drive <= 1'b0;
                ack_phase <= 1'b0;
                o_high_speed_operation <= 1'b0;
            end else if (start_cond) begin
                // Repeated starts land here too and keep high speed
                state <= ST_ADDR;
                bitcnt <= 4'h0;
                ack_drive <= 1'b0;
                tx_drive <= 1'b0;
                ack_phase <= 1'b0;
            end else if (state == ST_IDLE || state == ST_IGNORE) begin
                ack_drive <= 1'b0;
                tx_drive <= 1'b0;
            end else if (scl_rise) begin
                if (ack_phase) begin
                    read_nack <= sda_s; // Controller answer on a read byte
                end else begin
                    shreg <= shreg_next;
                    bitcnt <= bitcnt + 4'h1;
                end
            end else if (scl_fall) begin
                if (ack_phase) begin
                    // End of the ninth clock of a unit
                    ack_phase <= 1'b0;
                    ack_drive <= 1'b0;
                    bitcnt <= 4'h0;
                    if (state == ST_RDATA) begin
                        if (read_nack) begin
                            tx_drive <= 1'b0;
                            state <= ST_IGNORE;
                        end else begin
                            tx_byte <= rgi_read_mux(ptr, o_output_voltage_setpoint_low,
                                o_output_voltage_setpoint_high, o_converter_configuration,
                                o_latched_flag_report);
                            load_read <= 1'b1;
                            tx_drive <= 1'b1;
                        end
                    end
                end else if (state == ST_RDATA) begin
                    if (bitcnt == 4'h8) begin
                        tx_drive <= 1'b0; // Release for controller answer
                        ack_phase <= 1'b1;
                        ack_valid <= 1'b0;
                    end else begin
                        tx_byte <= {tx_byte[6:0], 1'b0};
                    end
                end else if (bitcnt == 4'h8) begin
                    // Eight bits in: decide the acknowledge
                    ack_phase <= 1'b1;
                    ack_valid <= 1'b1;
                    case (state)
                        ST_ADDR: begin
                            if (shreg[7:3] == `RGI_MASTER_CODE_TOP) begin
                                o_high_speed_operation <= 1'b1;
                                ack_valid <= 1'b0;
                                state <= ST_IGNORE; // Wait for repeated start
                            end else if (shreg[7:1] == own_addr) begin
                                ack_drive <= 1'b1;
                                if (shreg[0]) begin
                                    state <= ST_RDATA;
                                end else begin
                                    state <= ST_PTR;
                                end
                            end else begin
                                ack_valid <= 1'b0;
                                state <= ST_IGNORE;
                            end
                        end
                        ST_PTR: begin
                            ptr <= shreg[2:0];
                            ack_drive <= 1'b1;
                            // Pointer acknowledge is no commit point, else a read would write
                            ack_valid <= 1'b0;
                            state <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            ack_drive <= 1'b1;
                        end
                        default: begin
                            ack_valid <= 1'b0;
                            state <= ST_IGNORE;
                        end
                    endcase
                end
            end
            // Read byte is loaded on the fall ending the address acknowledge
            if (scl_fall & ack_phase & (state == ST_RDATA) & ack_valid & ~start_cond
                    & ~stop_cond) begin
                tx_byte <= rgi_read_mux(ptr, o_output_voltage_setpoint_low,
                    o_output_voltage_setpoint_high, o_converter_configuration,
                    o_latched_flag_report);
                load_read <= 1'b1;
                tx_drive <= 1'b1;
            end
        end
    end

    // Register bank; resets restore defaults, flags latch events
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_output_voltage_setpoint_low <= `RGI_SET_DEFAULT;
            o_output_voltage_setpoint_high <= `RGI_SET_DEFAULT;
            o_converter_configuration <= `RGI_CONFIG_DEFAULT;
            o_latched_flag_report <= `RGI_FLAGS_DEFAULT;
            o_startup_launch <= 1'b0;
        end else if (i_ce) begin
            o_startup_launch <= 1'b0;
            if (hw_reset | (write_ok & soft_reset)) begin
                o_output_voltage_setpoint_low <= `RGI_SET_DEFAULT;
                o_output_voltage_setpoint_high <= `RGI_SET_DEFAULT;
                o_converter_configuration <= `RGI_CONFIG_DEFAULT;
                o_latched_flag_report <= `RGI_FLAGS_DEFAULT;
                o_startup_launch <= write_ok & soft_reset;
            end else begin
                if (write_ok) begin
                    // Commit on falling edge of the data acknowledge clock
                    case (ptr)
                        `RGI_REG_SET_LOW: o_output_voltage_setpoint_low <= shreg;
                        `RGI_REG_SET_HIGH: o_output_voltage_setpoint_high <= shreg;
                        `RGI_REG_CONFIG: o_converter_configuration <= shreg;
                        default: o_converter_configuration <= o_converter_configuration;
                    endcase
                end
                // Read clears, but events in the same cycle still set
                o_latched_flag_report <= ((load_read && ptr == `RGI_REG_FLAGS) ?
                    8'h00 : o_latched_flag_report) |
                    {3'h0, i_evt_thermal_warn, i_evt_hiccup, 2'h0, i_evt_uvlo};
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/rgi_i2c_ctrl.sv
// Purpose: Behavioural I2C controller that drives SCL and SDA
// Assumes: Pull-up on both lines; bit period of 8 clocks (160 ns)
// Notes: Lines change only at the falling edge of the system clock
`timescale 1ns/10ps
`default_nettype none
module rgi_i2c_ctrl (
    // Clock
    input wire logic i_clk,
    // Bus
    input wire logic i_sda_bus,
    output logic o_scl,
    output logic o_sda
);
    // Both lines idle high; SCL stands still between frames
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // Quarter of a bit period
    task automatic tick();
        repeat (2) @(negedge i_clk);
    endtask
    // Start, or repeated start when SCL is low
    task automatic start();
        tick();
        o_sda = 1'b1;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda = 1'b0;
        tick();
        o_scl = 1'b0;
    endtask
    // Stop, then idle long enough for the target's synchroniser
    task automatic stop();
        tick();
        o_sda = 1'b0;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda = 1'b1;
        tick();
        tick();
    endtask
    // Data set in the low phase, sampled mid high phase
    task automatic bit_cyc(input logic b, output logic s);
        tick();
        o_sda = b;
        tick();
        o_scl = 1'b1;
        tick();
        s = i_sda_bus;
        tick();
        o_scl = 1'b0;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
            output logic nak);
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(tx[i], rx[i]);
        end
        bit_cyc(ak, nak);
    endtask
endmodule
`default_nettype wire

// >>> testbench/rgi_target_sva.sv
// Purpose: Port-level assertions for the regulator I2C target
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached to the design by bind
`timescale 1ns/10ps
`default_nettype none
module rgi_target_sva #(
    parameter STARTUP_WAIT_CYCLES = 50000
) (
    // Clocking
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Bus and power pins
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_oe_n,
    input wire logic i_enable,
    input wire logic i_supply_lost,
    input wire logic i_evt_uvlo,
    // Register contents
    input wire logic [7:0] o_output_voltage_setpoint_low,
    input wire logic [7:0] o_output_voltage_setpoint_high,
    input wire logic [7:0] o_converter_configuration,
    input wire logic [7:0] o_latched_flag_report,
    input wire logic o_startup_launch,
    input wire logic o_startup_busy,
    input wire logic o_high_speed_operation
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // All four registers at their defaults
    wire at_dflt = (o_output_voltage_setpoint_low == 8'h64)
        && (o_output_voltage_setpoint_high == 8'h64)
        && (o_converter_configuration == 8'h6F) && (o_latched_flag_report == 8'h00);
    // Stop: SDA rises while SCL stays high
    sequence stop_cond;
        i_scl && $past(i_scl) && $rose(i_sda);
    endsequence
    // No register reset source active; long enough to cover sync latency
    sequence quiet_run;
        (i_enable && !i_supply_lost && !o_startup_launch) [*6];
    endsequence
    reset_dflt_a: assert property (disable iff (1'b0) i_sys_rst |=> at_dflt && o_sda_oe_n)
        else $error("registers not at defaults after reset");
    stop_release_a: assert property (stop_cond |-> ##[1:6] (o_sda_oe_n && !o_high_speed_operation))
        else $error("bus held or high speed kept after stop");
    enable_fall_a: assert property ($fell(i_enable) |-> ##[2:6] at_dflt)
        else $error("enable fall did not restore defaults");
    supply_hold_a: assert property (i_supply_lost [*5] |-> at_dflt)
        else $error("supply loss did not hold defaults");
    launch_pulse_a: assert property (o_startup_launch |=> !o_startup_launch)
        else $error("start-up launch longer than one cycle");
    busy_follows_a: assert property (o_startup_launch |-> ##[1:2] o_startup_busy)
        else $error("start-up wait not running after launch");
    soft_dflt_a: assert property (o_startup_launch |-> ##[0:2] (at_dflt && !o_converter_configuration[7]))
        else $error("soft reset did not restore defaults");
    flag_latch_a: assert property (quiet_run ##0 i_evt_uvlo |=> o_latched_flag_report[0])
        else $error("undervoltage flag not latched");
endmodule
bind rgi_target rgi_target_sva #(.STARTUP_WAIT_CYCLES(STARTUP_WAIT_CYCLES)) u_sva (
    .i_clk, .i_sys_rst, .i_scl, .i_sda, .o_sda_oe_n, .i_enable, .i_supply_lost, .i_evt_uvlo,
    .o_output_voltage_setpoint_low, .o_output_voltage_setpoint_high,
    .o_converter_configuration, .o_latched_flag_report, .o_startup_launch,
    .o_startup_busy, .o_high_speed_operation
);
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the regulator I2C target
// Assumes: Controller model on the bus, 160 ns bit period
// Notes: Start-up wait shortened, but longer than one write transfer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int WAIT_CYC = 600;
    localparam logic [7:0] DFLT [0:7] = '{8'h00, 8'h64, 8'h64, 8'h6F, 8'h00, 8'h00, 8'h00, 8'h00};
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_enable = 1'b1;
    logic i_supply_lost = 1'b0;
    logic [2:0] evt = 3'h0;
    logic [5:0] strap = 6'h2A;
    logic oe_n, o_sda, scl, ctl_sda, launch, busy, hso, nak;
    logic [7:0] lo, hi, cfg, flg, rx;
    int err_total = 0;
    int comparisons = 0;
    // Open-drain bus with pull-up: low if either side pulls it
    wire logic sda_bus = ctl_sda & (oe_n | o_sda);
    always #10 i_clk = ~i_clk;
    rgi_i2c_ctrl ctl (.i_clk(i_clk), .i_sda_bus(sda_bus), .o_scl(scl), .o_sda(ctl_sda));
    rgi_target #(.STARTUP_WAIT_CYCLES(WAIT_CYC)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_scl(scl), .i_sda(sda_bus),
        .o_sda(o_sda), .o_sda_oe_n(oe_n), .i_addr_strap(strap), .i_enable(i_enable),
        .i_supply_lost(i_supply_lost), .i_evt_thermal_warn(evt[2]), .i_evt_hiccup(evt[1]),
        .i_evt_uvlo(evt[0]), .o_output_voltage_setpoint_low(lo),
        .o_output_voltage_setpoint_high(hi), .o_converter_configuration(cfg),
        .o_latched_flag_report(flg), .o_startup_launch(launch), .o_startup_busy(busy),
        .o_high_speed_operation(hso)
    );
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    // Address, pointer and data, each answered in the ninth clock
    task automatic reg_wr(input logic [6:0] a, input logic [2:0] r, input logic [7:0] d,
            input logic en);
        ctl.start();
        ctl.xfer({a, 1'b0}, 1'b1, rx, nak);
        chk_bit(nak, en);
        ctl.xfer({5'h00, r}, 1'b1, rx, nak);
        chk_bit(nak, en);
        ctl.xfer(d, 1'b1, rx, nak);
        chk_bit(nak, en);
        ctl.stop();
    endtask
    // Pointer write, repeated start, one byte read and not acknowledged
    task automatic reg_rd(input logic [2:0] r, input logic [7:0] exp);
        ctl.start();
        ctl.xfer({1'b1, strap, 1'b0}, 1'b1, rx, nak);
        ctl.xfer({5'h00, r}, 1'b1, rx, nak);
        ctl.start();
        ctl.xfer({1'b1, strap, 1'b1}, 1'b1, rx, nak);
        chk_bit(nak, 1'b0);
        ctl.xfer(8'hFF, 1'b1, rx, nak);
        chk_byte(rx, exp);
        ctl.stop();
    endtask
    task automatic conclude();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        for (int i = 0; i < 8; i++) reg_rd(3'(i), DFLT[i]);
        $display("test defaults done");
        reg_wr({1'b1, strap}, 3'h1, 8'h10, 1'b0);
        reg_wr({1'b1, strap}, 3'h2, 8'hA5, 1'b0);
        reg_wr({1'b1, strap}, 3'h5, 8'hFF, 1'b0);
        reg_wr({1'b1, ~strap}, 3'h1, 8'hEE, 1'b1);
        chk_byte(lo, 8'h10);
        chk_byte(hi, 8'hA5);
        reg_rd(3'h2, 8'hA5);
        reg_rd(3'h5, 8'h00);
        $display("test write done");
        evt = 3'h7;
        @(negedge i_clk);
        evt = 3'h0;
        reg_rd(3'h5, 8'h19);
        reg_rd(3'h5, 8'h00);
        $display("test flags done");
        ctl.start();
        ctl.xfer(8'h0B, 1'b1, rx, nak);
        chk_bit(nak, 1'b1);
        chk_bit(hso, 1'b1);
        reg_wr({1'b1, strap}, 3'h1, 8'h77, 1'b0);
        repeat (4) @(negedge i_clk);
        chk_bit(hso, 1'b0);
        reg_rd(3'h1, 8'h77);
        $display("test high speed done");
        reg_wr({1'b1, strap}, 3'h3, 8'h80, 1'b0);
        chk_byte(lo, 8'h64);
        chk_byte(cfg, 8'h6F);
        chk_bit(busy, 1'b1);
        reg_wr({1'b1, strap}, 3'h1, 8'h55, 1'b0);
        chk_byte(lo, 8'h64);
        for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge i_clk);
        if (busy !== 1'b0) begin
            err_total++;
            conclude();
        end
        reg_wr({1'b1, strap}, 3'h1, 8'h55, 1'b0);
        chk_byte(lo, 8'h55);
        $display("test soft reset done");
        i_enable = 1'b0;
        repeat (8) @(negedge i_clk);
        chk_byte(lo, 8'h64);
        i_enable = 1'b1;
        reg_wr({1'b1, strap}, 3'h1, 8'h21, 1'b0);
        i_supply_lost = 1'b1;
        repeat (8) @(negedge i_clk);
        chk_byte(lo, 8'h64);
        i_supply_lost = 1'b0;
        repeat (4) @(negedge i_clk);
        reg_rd(3'h1, 8'h64);
        $display("test power done");
        conclude();
    end
endmodule
`default_nettype wire
